// file: qcr_core.sv
// Quadrature counter core with reference distance and touch-probe capture
`timescale 1ns/1ps
module qcr_core
  import qcr_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        CE,
  input  wire logic        AP,
  input  wire logic        AN,
  input  wire logic        BP,
  input  wire logic        BN,
  input  wire logic        CP,
  input  wire logic        CN,
  input  wire logic        PROBE_PIN,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [6:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [47:0] REG_RDATA,
  output logic      [1:0]  ACT,
  output logic             RX_SINGLE_END,
  output logic             RX_LVDS,
  output logic             REFERENCE_VALID,
  output logic             UPDATE_VALID,
  output logic             PROBE_VALID,
  output logic      [2:0]  DECODE_ERR
);

  logic [7:0]  cfg_cnt;
  logic [7:0]  cfg_idx;
  logic [7:0]  cfg_std;
  logic [7:0]  cfg_ch;
  logic [SYNC_STAGES*7-1:0] sync_chain;
  logic [6:0]  pins;
  logic [2:0]  partition;
  logic        single_end;
  logic        exch_sel;
  logic [1:0]  nch;
  logic [5:0]  off   [3];
  logic [47:0] msk   [3];
  logic [47:0] rd_mask;
  logic [2:0]  a_raw, b_raw, a_now, b_now, a_prev, b_prev;
  logic [2:0]  step_up, step_dn, dec_err;
  logic [1:0]  z_raw, z_act, z_qual, z_qual_prev, idx_has, idx_ev;
  logic        z_ref_prev, ref_idx;
  logic [2:0]  clr;
  logic [47:0] cnt, next_cnt;
  logic [23:0] ref_cnt, update_distance, reference_distance;
  logic [23:0] capture_first, capture_second;
  logic [6:0]  instr;
  logic        probe_prev, probe_ev;
  logic        ref_load;
  logic        wr_instr;
  qcr_zc_t     zc_state;

  assign partition  = cfg_cnt[POS_PARTITION +: 3];
  assign single_end = cfg_idx[POS_SINGLE_END];
  assign exch_sel   = cfg_ch[POS_EXCH_SEL];
  assign wr_instr   = REG_WR && (REG_ADDR == ADDR_INSTR);

  // Configuration registers, plain read/write
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_cnt <= RST_CFG;
      cfg_idx <= RST_CFG;
      cfg_std <= RST_CFG;
      cfg_ch  <= RST_CFG;
    end else if (CE && REG_WR) begin
      case (REG_ADDR)
        ADDR_CNT_CFG: cfg_cnt <= REG_WDATA;
        ADDR_IDX_CFG: cfg_idx <= REG_WDATA;
        ADDR_STD_CFG: cfg_std <= REG_WDATA;
        ADDR_CH_CFG:  cfg_ch  <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // Instruction strobes live one cycle; actuators keep value
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      instr <= 7'h00;
    end else if (CE) begin
      instr[4:0] <= wr_instr ? REG_WDATA[4:0] : 5'h00;
      if (wr_instr) begin
        instr[6:5] <= REG_WDATA[POS_ACT0 +: 2];
      end
    end
  end

  // Front-end standard straight to the receiver controls
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RX_SINGLE_END <= 1'b0;
      RX_LVDS       <= 1'b0;
      ACT           <= 2'h0;
    end else if (CE) begin
      RX_SINGLE_END <= single_end;
      RX_LVDS       <= !single_end && cfg_std[POS_LVDS];
      ACT           <= instr[6:5];
    end
  end

  // Pin synchroniser; only the last stage feeds logic
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync_chain <= '0;
    end else if (CE) begin
      sync_chain <= {sync_chain[SYNC_STAGES*7-8:0],
                     PROBE_PIN, CN, CP, BN, BP, AN, AP};
    end
  end
  assign pins = sync_chain[SYNC_STAGES*7-1 -: 7];

  // Field layout of the shared 48-bit counter
  always_comb begin
    nch    = 2'd1;
    off[0] = 6'd0;
    off[1] = 6'd0;
    off[2] = 6'd0;
    msk[0] = 48'h0000_00ff_ffff;
    msk[1] = 48'h0;
    msk[2] = 48'h0;
    rd_mask = 48'h0000_00ff_ffff;
    case (partition)
      PART_24: ;
      PART_24_24: begin
        nch = 2'd2; off[1] = 6'd24; msk[1] = 48'h0000_00ff_ffff;
        rd_mask = 48'hffff_ffff_ffff;
      end
      PART_48: begin
        msk[0] = 48'hffff_ffff_ffff; rd_mask = 48'hffff_ffff_ffff;
      end
      PART_16: begin
        msk[0] = 48'h0000_0000_ffff; rd_mask = 48'h0000_0000_ffff;
      end
      PART_32: begin
        msk[0] = 48'h0000_ffff_ffff; rd_mask = 48'h0000_ffff_ffff;
      end
      PART_32_16: begin
        nch = 2'd2; msk[0] = 48'h0000_ffff_ffff;
        off[1] = 6'd32; msk[1] = 48'h0000_0000_ffff;
        rd_mask = 48'hffff_ffff_ffff;
      end
      PART_16_16: begin
        nch = 2'd2; msk[0] = 48'h0000_0000_ffff;
        off[1] = 6'd16; msk[1] = 48'h0000_0000_ffff;
        rd_mask = 48'h0000_ffff_ffff;
      end
      PART_16_3: begin
        nch = 2'd3; msk[0] = 48'h0000_0000_ffff;
        off[1] = 6'd16; msk[1] = 48'h0000_0000_ffff;
        off[2] = 6'd32; msk[2] = 48'h0000_0000_ffff;
        rd_mask = 48'hffff_ffff_ffff;
      end
      default: ;
    endcase
    // Differential receivers only serve one counter
    if (!single_end) begin
      nch = 2'd1;
    end
  end

  // Pin routing to channel A, B and index
  always_comb begin
    a_raw = 3'h0;
    b_raw = 3'h0;
    z_raw = 2'h0;
    if (!single_end) begin
      a_raw[0] = pins[0]; b_raw[0] = pins[2]; z_raw[0] = pins[4];
    end else if (nch == 2'd3) begin
      a_raw = {pins[4], pins[2], pins[0]};
      b_raw = {pins[5], pins[3], pins[1]};
    end else begin
      a_raw[1:0] = {pins[3], pins[0]};
      b_raw[1:0] = {pins[4], pins[1]};
      z_raw      = {pins[5], pins[2]};
    end
  end

  // Per-channel quadrature decode, fourfold edge counting
  for (genvar i = 0; i < 3; i++) begin : g_dec
    assign a_now[i] = cfg_cnt[POS_SWAP0+i] ? b_raw[i] : a_raw[i];
    assign b_now[i] = cfg_cnt[POS_SWAP0+i] ? a_raw[i] : b_raw[i];
    // Both phases moving at once gives no direction
    assign dec_err[i] = (a_now[i] ^ a_prev[i]) && (b_now[i] ^ b_prev[i]);
    assign step_up[i] = !dec_err[i] && (a_now[i] ^ a_prev[i] ^ b_now[i] ^ b_prev[i])
                        && (a_now[i] ^ b_prev[i]);
    assign step_dn[i] = !dec_err[i] && (a_now[i] ^ a_prev[i] ^ b_now[i] ^ b_prev[i])
                        && !(a_now[i] ^ b_prev[i]);

    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        a_prev[i]     <= 1'b0;
        b_prev[i]     <= 1'b0;
        DECODE_ERR[i] <= 1'b0;
      end else if (CE) begin
        a_prev[i] <= a_now[i];
        b_prev[i] <= b_now[i];
        // Sticky until that counter's clear instruction (index clears leave it); error wins
        if (dec_err[i] && (i < nch)) begin
          DECODE_ERR[i] <= 1'b1;
        end else if (instr[POS_CLR0+i]) begin
          DECODE_ERR[i] <= 1'b0;
        end
      end
    end
  end

  // Index inversion and A/B qualification
  for (genvar i = 0; i < 2; i++) begin : g_idx
    assign z_act[i]  = z_raw[i] ^ cfg_cnt[POS_INVERT0+i];
    assign z_qual[i] = z_act[i]
        && (a_raw[i] == !cfg_idx[POS_QUALIFY+1])
        && (b_raw[i] == !cfg_idx[POS_QUALIFY]);
    assign idx_ev[i] = idx_has[i] && z_qual[i] && !z_qual_prev[i];
    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        z_qual_prev[i] <= 1'b0;
      end else if (CE) begin
        z_qual_prev[i] <= z_qual[i];
      end
    end
  end
  // No index in the three-counter layout
  assign idx_has[0] = (nch != 2'd3);
  assign idx_has[1] = (nch == 2'd2);

  // Reference index ignores qualification on purpose
  assign ref_idx  = idx_has[0] && z_act[0] && !z_ref_prev;
  assign ref_load = (zc_state == ZC_SECOND) && ref_idx
                    && (ref_cnt != 24'h0) && !instr[POS_ZC_START];

  // Counter clears: instruction, early indexes, enabled index
  always_comb begin
    clr    = instr[2:0];
    clr[0] = clr[0] || ref_load || (idx_ev[0] && ((zc_state != ZC_DONE)
             || cfg_idx[POS_CLEAR_EN0]));
    clr[1] = clr[1] || (idx_ev[1] && ((zc_state != ZC_DONE)
             || cfg_idx[POS_CLEAR_EN0+1]));
  end

  // Field-wise update; carries never cross a field boundary
  always_comb begin
    logic [47:0] f;
    f = 48'h0;
    next_cnt = cnt;
    if (!exch_sel) begin
      for (int i = 0; i < 3; i++) begin
        if (i < int'(nch)) begin
          f = (next_cnt >> off[i]) & msk[i];
          if (clr[i]) begin
            f = 48'h0;
          end else if (step_up[i]) begin
            f = f + 48'h1;
          end else if (step_dn[i]) begin
            f = f - 48'h1;
          end
          next_cnt = (next_cnt & ~(msk[i] << off[i]))
                     | ((f & msk[i]) << off[i]);
        end
      end
    end
  end

  // Counter, doubling as exchange buffer when selected
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt <= 48'h0;
    end else if (CE) begin
      if (exch_sel && REG_WR && REG_ADDR >= ADDR_EXCH_FIRST
          && REG_ADDR <= ADDR_EXCH_LAST) begin
        cnt[8*(ADDR_EXCH_LAST - REG_ADDR) +: 8] <= REG_WDATA;
      end else begin
        cnt <= next_cnt;
      end
    end
  end

  // Zero codification sequence, restarted by instruction
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      zc_state <= ZC_FIRST;
    end else if (CE) begin
      if (instr[POS_ZC_START]) begin
        zc_state <= ZC_FIRST;
      end else begin
        case (zc_state)
          ZC_FIRST:  if (ref_idx) zc_state <= ZC_SECOND;
          ZC_SECOND: if (ref_load) zc_state <= ZC_DONE;
          ZC_DONE:   ;
          default:   zc_state <= ZC_FIRST;
        endcase
      end
    end
  end

  // Hidden reference counter and the update register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ref_cnt            <= 24'h0;
      z_ref_prev         <= 1'b0;
      update_distance    <= 24'h0;
      reference_distance <= 24'h0;
    end else if (CE) begin
      z_ref_prev <= z_act[0];
      if (ref_idx) begin
        ref_cnt         <= 24'h0;
        update_distance <= ref_cnt;
      end else if (step_up[0]) begin
        ref_cnt <= ref_cnt + 24'h1;
      end else if (step_dn[0]) begin
        ref_cnt <= ref_cnt - 24'h1;
      end
      if (ref_load) begin
        reference_distance <= ref_cnt;
      end
    end
  end

  // Valid flags; a new event wins over a clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      REFERENCE_VALID <= 1'b0;
      UPDATE_VALID    <= 1'b0;
      PROBE_VALID     <= 1'b0;
    end else if (CE) begin
      if (ref_load) begin
        REFERENCE_VALID <= 1'b1;
      end else if (instr[POS_ZC_START] || instr[POS_CLR0]) begin
        REFERENCE_VALID <= 1'b0;
      end
      if (ref_idx) begin
        UPDATE_VALID <= 1'b1;
      end else if (REG_RD && REG_ADDR == ADDR_UPDATE) begin
        UPDATE_VALID <= 1'b0;
      end
      if (probe_ev || instr[POS_PROBE]) begin
        PROBE_VALID <= 1'b1;
      end else if (REG_RD && (REG_ADDR == ADDR_CAP_FIRST
                   || REG_ADDR == ADDR_CAP_SEC)) begin
        PROBE_VALID <= 1'b0;
      end
    end
  end

  // Probe pin edge selection
  always_comb begin
    case (cfg_idx[POS_PROBE_EDGE +: 2])
      EDGE_BOTH: probe_ev = pins[6] ^ probe_prev;
      EDGE_RISE: probe_ev = pins[6] && !probe_prev;
      EDGE_FALL: probe_ev = !pins[6] && probe_prev;
      default:   probe_ev = 1'b0;
    endcase
  end

  // Capture pair; only the low 24 bits of the shared counter are taken
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      probe_prev     <= 1'b0;
      capture_first  <= 24'h0;
      capture_second <= 24'h0;
    end else if (CE) begin
      probe_prev <= pins[6];
      if (probe_ev || instr[POS_PROBE]) begin
        capture_second <= capture_first;
        capture_first  <= cnt[23:0];
      end
    end
  end

  // Read port, one cycle after the strobe
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 48'h0;
    end else if (CE && REG_RD) begin
      case (REG_ADDR)
        ADDR_CNT_CFG:   REG_RDATA <= {40'h0, cfg_cnt};
        ADDR_IDX_CFG:   REG_RDATA <= {40'h0, cfg_idx};
        ADDR_STD_CFG:   REG_RDATA <= {40'h0, cfg_std};
        ADDR_CH_CFG:    REG_RDATA <= {40'h0, cfg_ch};
        ADDR_POSITION:  REG_RDATA <= exch_sel ? cnt
                                     : (cnt & rd_mask);
        ADDR_UPDATE:    REG_RDATA <= {22'h0, update_distance,
                                      !DECODE_ERR[0], !UPDATE_VALID};
        ADDR_CAP_FIRST: REG_RDATA <= {22'h0, capture_first,
                                      !DECODE_ERR[0], !PROBE_VALID};
        ADDR_CAP_SEC:   REG_RDATA <= {22'h0, capture_second,
                                      !DECODE_ERR[0], !PROBE_VALID};
        ADDR_REF_DIST:  REG_RDATA <= {24'h0, reference_distance};
        default:        REG_RDATA <= 48'h0;
      endcase
    end
  end

endmodule

// file: qcr_core_checker.sv
// Port-level assertions for the quadrature counter core
`timescale 1ns/1ps
module qcr_core_checker
  import qcr_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        CE,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [6:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic [47:0] REG_RDATA,
  input wire logic [1:0]  ACT,
  input wire logic        REFERENCE_VALID,
  input wire logic        UPDATE_VALID,
  input wire logic        PROBE_VALID,
  input wire logic [2:0]  DECODE_ERR
);
  logic ins;
  logic clr0;
  logic clr_ref;
  logic rd_upd;
  logic rd_cap;
  // Bus events that the flags depend on
  assign ins = CE && REG_WR && REG_ADDR == ADDR_INSTR;
  assign clr0 = ins && REG_WDATA[0];
  assign clr_ref = ins && (REG_WDATA[0] || REG_WDATA[3]);
  assign rd_upd = CE && REG_RD && REG_ADDR == ADDR_UPDATE;
  assign rd_cap = CE && REG_RD && (REG_ADDR == ADDR_CAP_FIRST
                  || REG_ADDR == ADDR_CAP_SEC);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // Instruction write and its strobe slot; update read and its answer
  sequence s_ins;
    ins ##2 1'b1;
  endsequence
  sequence s_rd_upd;
    rd_upd ##1 1'b1;
  endsequence
  property p_act_set;
    s_ins |-> ACT == $past(REG_WDATA[6:5], 2);
  endproperty
  a_act_set: assert property (p_act_set)
    else $error("actuator level not taken from write");
  property p_act_hold;
    $changed(ACT) |-> $past(ins) || $past(ins, 2);
  endproperty
  a_act_hold: assert property (p_act_hold)
    else $error("actuator level moved without write");
  property p_upd_nv;
    s_rd_upd |-> REG_RDATA[0] == !$past(UPDATE_VALID);
  endproperty
  a_upd_nv: assert property (p_upd_nv)
    else $error("update not-valid bit wrong");
  property p_upd_fall;
    $fell(UPDATE_VALID) |-> $past(rd_upd) || $past(rd_upd, 2);
  endproperty
  a_upd_fall: assert property (p_upd_fall)
    else $error("update valid dropped without read");
  property p_tp_fall;
    $fell(PROBE_VALID) |-> $past(rd_cap) || $past(rd_cap, 2);
  endproperty
  a_tp_fall: assert property (p_tp_fall)
    else $error("probe valid dropped without read");
  property p_ref_fall;
    $fell(REFERENCE_VALID) |-> $past(clr_ref) || $past(clr_ref, 2);
  endproperty
  a_ref_fall: assert property (p_ref_fall)
    else $error("reference valid dropped without cause");
  property p_err_fall;
    $fell(DECODE_ERR[0]) |-> $past(clr0) || $past(clr0, 2);
  endproperty
  a_err_fall: assert property (p_err_fall)
    else $error("decode error dropped without clear");
  property p_rd_hold;
    !(CE && REG_RD) |=> $stable(REG_RDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
endmodule

bind qcr_core qcr_core_checker qcr_core_checker_i (.CLK(CLK), .RST_B(RST_B),
  .CE(CE), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .ACT(ACT),
  .REFERENCE_VALID(REFERENCE_VALID), .UPDATE_VALID(UPDATE_VALID),
  .PROBE_VALID(PROBE_VALID), .DECODE_ERR(DECODE_ERR));

// file: qcr_core_tb.sv
// Self-checking bench for the quadrature counter core
`timescale 1ns/1ps
module qcr_core_tb
  import qcr_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  logic        se = 1'b0;
  logic        pin = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [6:0]  addr = 7'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  tpe = 8'hc9;
  logic [47:0] rdata;
  logic [1:0]  act;
  logic [2:0]  derr;
  logic        rx_se, rx_lvds, ref_v, upd_v, tp_v;
  logic        ap, an, bp, bn, cp, cn;
  int          fails = 0;
  int          samples_checked = 0;

  qcr_enc qcr_enc_i (.clk(clk), .se(se), .ap(ap), .an(an), .bp(bp),
    .bn(bn), .cp(cp), .cn(cn));
  qcr_core qcr_core_i (.CLK(clk), .RST_B(rst_b), .CE(ce), .AP(ap), .AN(an),
    .BP(bp), .BN(bn), .CP(cp), .CN(cn), .PROBE_PIN(pin), .REG_WR(wr),
    .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .ACT(act), .RX_SINGLE_END(rx_se), .RX_LVDS(rx_lvds),
    .REFERENCE_VALID(ref_v), .UPDATE_VALID(upd_v), .PROBE_VALID(tp_v),
    .DECODE_ERR(derr));

  // 100 MHz clock
  initial forever #5 clk = ~clk;

  function automatic logic [47:0] f1(input logic x);
    return {47'h0, x};
  endfunction
  // Word layout of update and capture reads, no decode error pending
  function automatic logic [47:0] fmt(input logic [23:0] v, input logic nv);
    return {22'h0, v, 1'b1, nv};
  endfunction
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Strobes held through the taking edge, released on the next falling one
  task automatic wreg(input logic [6:0] a, input logic [7:0] v);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = v;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [6:0] a, input logic [47:0] e, input string nm);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk(nm, e, rdata);
  endtask
  // Two indexes 8 edges apart from a parked A=B=0 shaft
  task automatic zc_run();
    qcr_enc_i.step(2);
    qcr_enc_i.mark();
    chk("ref_valid", 48'h0, f1(ref_v));
    qcr_enc_i.step(8);
    qcr_enc_i.mark();
    chk("ref_valid", 48'h1, f1(ref_v));
    rreg(ADDR_REF_DIST, 48'h8, "ref_dist");
    rreg(ADDR_POSITION, 48'h0, "position");
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard, well beyond the seven hundred or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("MISMATCH watchdog expected done seen timeout");
    summarize();
  end

  // Test sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    zc_run();
    rreg(ADDR_UPDATE, fmt(24'h8, 1'b0), "update");
    chk("update_valid", 48'h0, f1(upd_v));
    $display("TEST zero_codify done");
    qcr_enc_i.step(4);
    qcr_enc_i.mark();
    rreg(ADDR_POSITION, 48'h4, "position");
    rreg(ADDR_UPDATE, fmt(24'h4, 1'b0), "update");
    // Clear enabled; only code 00 accepts an index at A=B=1
    for (int q = 0; q < 4; q++) begin
      wreg(ADDR_IDX_CFG, 8'h20 | 8'(q << 3));
      qcr_enc_i.step(4);
      qcr_enc_i.mark();
      rreg(ADDR_POSITION, 48'(4 * q), "position");
    end
    $display("TEST index done");
    wreg(ADDR_CNT_CFG, 8'h08);
    qcr_enc_i.step(16);
    rreg(ADDR_POSITION, 48'hff_fffc, "position");
    wreg(ADDR_CNT_CFG, 8'h00);
    qcr_enc_i.step(4);
    rreg(ADDR_POSITION, 48'h0, "position");
    qcr_enc_i.glitch();
    chk("decode_err", 48'h1, {45'h0, derr});
    rreg(ADDR_POSITION, 48'h0, "position");
    wreg(ADDR_INSTR, 8'h01);
    repeat (2) @(negedge clk);
    chk("decode_err", 48'h0, {45'h0, derr});
    chk("ref_valid", 48'h0, f1(ref_v));
    $display("TEST direction done");
    // Edge codes 01,01,10,10,11,11,00,00 against rise, fall, rise, ...
    for (int i = 0; i < 8; i++) begin
      wreg(ADDR_IDX_CFG, 8'((((i >> 1) + 1) % 4) << 1));
      pin = !i[0];
      repeat (6) @(negedge clk);
      chk("probe_valid", f1(tpe[i]), f1(tp_v));
      rreg(ADDR_CAP_FIRST, fmt(24'h0, !tpe[i]), "capture_first");
    end
    qcr_enc_i.step(4);
    wreg(ADDR_INSTR, 8'h10);
    qcr_enc_i.step(4);
    wreg(ADDR_INSTR, 8'h10);
    rreg(ADDR_CAP_FIRST, fmt(24'h8, 1'b0), "capture_first");
    rreg(ADDR_CAP_SEC, fmt(24'h4, 1'b1), "capture_second");
    $display("TEST probe done");
    wreg(ADDR_INSTR, 8'h60);
    repeat (2) @(negedge clk);
    chk("act", 48'h3, {46'h0, act});
    ce = 1'b0;
    wreg(ADDR_INSTR, 8'h20);
    chk("act", 48'h3, {46'h0, act});
    ce = 1'b1;
    wreg(ADDR_INSTR, 8'h20);
    repeat (2) @(negedge clk);
    chk("act", 48'h1, {46'h0, act});
    // Exchange buffer at full length, counting frozen meanwhile
    wreg(ADDR_CNT_CFG, 8'h02);
    wreg(ADDR_CH_CFG, 8'h08);
    for (int i = 0; i < 6; i++) wreg(7'(ADDR_EXCH_FIRST + i), 8'(17 * (i + 1)));
    qcr_enc_i.step(4);
    rreg(ADDR_POSITION, 48'h1122_3344_5566, "exchange");
    wreg(ADDR_REF_DIST, 8'hff);
    rreg(ADDR_REF_DIST, 48'h8, "ref_dist");
    rreg(7'h7f, 48'h0, "unmapped");
    $display("TEST exchange done");
    wreg(ADDR_CH_CFG, 8'h00);
    wreg(ADDR_STD_CFG, 8'h80);
    repeat (2) @(negedge clk);
    chk("rx_lvds", 48'h1, f1(rx_lvds));
    wreg(ADDR_IDX_CFG, 8'h80);
    se = 1'b1;
    repeat (4) @(negedge clk);
    chk("rx_lvds", 48'h0, f1(rx_lvds));
    chk("rx_single", 48'h1, f1(rx_se));
    wreg(ADDR_INSTR, 8'h01);
    qcr_enc_i.step(4);
    rreg(ADDR_POSITION, 48'h4, "position");
    wreg(ADDR_INSTR, 8'h08);
    zc_run();
    // Two 16-bit counters fed from the mirrored second pin set
    wreg(ADDR_CNT_CFG, 8'h06);
    wreg(ADDR_INSTR, 8'h03);
    qcr_enc_i.step(4);
    rreg(ADDR_POSITION, 48'h0000_0004_0004, "position_2x16");
    $display("TEST inputs done");
    summarize();
  end
endmodule

// file: qcr_enc.sv
// Incremental encoder model with A, B and index tracks for the core bench
`timescale 1ns/1ps
module qcr_enc (
  input  wire logic clk,
  input  wire logic se,
  output logic      ap,
  output logic      an,
  output logic      bp,
  output logic      bn,
  output logic      cp,
  output logic      cn
);
  logic [1:0] ph = 2'b00;
  logic       z  = 1'b0;
  // Pair or single-ended routing; single-ended mode mirrors the shaft
  // onto the second counter's pins so a two-counter split sees it too
  always_comb begin
    ap = ph[1];
    an = se ? ph[0] : !ph[1];
    bp = se ? z : ph[0];
    bn = se ? ph[1] : !ph[0];
    cp = se ? ph[0] : z;
    cn = se ? z : !z;
  end
  // Forward edges only, A leads B; spaced so every edge is sampled apart
  task automatic step(input int n);
    repeat (n) begin
      @(negedge clk);
      ph = {!ph[0], ph[1]};
      repeat (4) @(negedge clk);
    end
  endtask
  // Index pulse, only issued while parked at A=B=1
  task automatic mark();
    @(negedge clk);
    z = 1'b1;
    repeat (4) @(negedge clk);
    z = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // Both tracks flip in one sample, a deliberate fault
  task automatic glitch();
    @(negedge clk);
    ph = ~ph;
    repeat (6) @(negedge clk);
  endtask
endmodule

// file: qcr_pkg.sv
// Constants shared by the quadrature counter and reference capture core
package qcr_pkg;
  // Register addresses
  localparam logic [6:0] ADDR_CNT_CFG   = 7'h00;
  localparam logic [6:0] ADDR_IDX_CFG   = 7'h01;
  localparam logic [6:0] ADDR_STD_CFG   = 7'h03;
  localparam logic [6:0] ADDR_CH_CFG    = 7'h04;
  localparam logic [6:0] ADDR_POSITION  = 7'h08;
  localparam logic [6:0] ADDR_UPDATE    = 7'h0a;
  localparam logic [6:0] ADDR_CAP_FIRST = 7'h0c;
  localparam logic [6:0] ADDR_CAP_SEC   = 7'h0e;
  localparam logic [6:0] ADDR_REF_DIST  = 7'h10;
  localparam logic [6:0] ADDR_EXCH_FIRST = 7'h20;
  localparam logic [6:0] ADDR_EXCH_LAST = 7'h25;
  localparam logic [6:0] ADDR_INSTR     = 7'h30;
  // Field positions in counter_input_config
  localparam int POS_PARTITION = 0;
  localparam int POS_SWAP0     = 3;
  localparam int POS_INVERT0   = 6;
  // Field positions in index_probe_config
  localparam int POS_PROBE_EDGE = 1;
  localparam int POS_QUALIFY    = 3;
  localparam int POS_CLEAR_EN0  = 5;
  localparam int POS_SINGLE_END = 7;
  // Field positions in input_standard_config and channel config
  localparam int POS_LVDS      = 7;
  localparam int POS_EXCH_SEL  = 3;
  // Instruction byte bits
  localparam int POS_CLR0      = 0;
  localparam int POS_ZC_START  = 3;
  localparam int POS_PROBE     = 4;
  localparam int POS_ACT0      = 5;
  // Reset values
  localparam logic [7:0] RST_CFG = 8'h00;
  // Partition codes
  localparam logic [2:0] PART_24     = 3'h0;
  localparam logic [2:0] PART_24_24  = 3'h1;
  localparam logic [2:0] PART_48     = 3'h2;
  localparam logic [2:0] PART_16     = 3'h3;
  localparam logic [2:0] PART_32     = 3'h4;
  localparam logic [2:0] PART_32_16  = 3'h5;
  localparam logic [2:0] PART_16_16  = 3'h6;
  localparam logic [2:0] PART_16_3   = 3'h7;
  // Probe edge codes
  localparam logic [1:0] EDGE_BOTH    = 2'h0;
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  // Zero codification states
  typedef enum logic [1:0] {ZC_FIRST, ZC_SECOND, ZC_DONE} qcr_zc_t;
endpackage
